/* File: design/ptc_pkg.sv */
`default_nettype none
package ptc_pkg;
  // Baseband trigger styles
  typedef enum logic [1:0] {PTC_BB_CONT, PTC_BB_SINGLE, PTC_BB_GATE} ptc_bb_style_e;
  // Arbitrary trigger styles
  typedef enum logic [2:0] {
    PTC_ARB_CONT, PTC_ARB_IGNORE, PTC_ARB_BUFFER, PTC_ARB_RESTART, PTC_ARB_SEGSINGLE,
    PTC_ARB_GATE
  } ptc_arb_style_e;
  // Trigger sources
  typedef enum logic [1:0] {PTC_SRC_KEY, PTC_SRC_EXT, PTC_SRC_BUS, PTC_SRC_INT} ptc_src_e;
  localparam int PTC_DLY_W = 16;
  localparam int PTC_LEN_W = 16;
  localparam int PTC_SEG_W = 3;
  localparam int PTC_SEG_N = 8;
  localparam logic [PTC_DLY_W-1:0] PTC_DLY_ZERO = 16'h0000;
  localparam logic [PTC_LEN_W-1:0] PTC_LEN_ONE = 16'h0001;
  localparam logic [PTC_SEG_W-1:0] PTC_SEG_FIRST = 3'h0;
  // Trigger configuration shared by both engines
  typedef struct packed {
    ptc_src_e src;
    logic pol_neg;
    logic dly_en;
    logic [PTC_DLY_W-1:0] dly;
  } ptc_trig_cfg_s;
  // Playback status towards a sample engine
  typedef struct packed {
    logic play;
    logic start;
    logic [PTC_SEG_W-1:0] seg;
  } ptc_play_s;
endpackage
`default_nettype wire

/* File: design/ptc_seg_mem.sv */
`default_nettype none
// Segment length table, registered read
module ptc_seg_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [ptc_pkg::PTC_SEG_W-1:0] waddr,
  input wire logic [ptc_pkg::PTC_LEN_W-1:0] wdata,
  input wire logic [ptc_pkg::PTC_SEG_W-1:0] raddr,
  output logic [ptc_pkg::PTC_LEN_W-1:0] rdata
);
  logic [ptc_pkg::PTC_LEN_W-1:0] mem [ptc_pkg::PTC_SEG_N];
  // No reset: software loads lengths before enabling playback
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: design/ptc_top.sv */
`default_nettype none
// Summary of operation
// - Baseband single: one playback per trigger that arrives while idle
// - Baseband gate high: play while gate high
// - Baseband gate low: play while gate low
// - Gate style forces external source, gate polarity
// - Baseband gate plays continuously while active
// - Arb sources: key, external, bus, internal
// - External polarity selectable, optional switchable delay
// - Arb continuous: every trigger restarts segment
// - Single ignore: triggers during playback discarded
// - Single buffer: trigger recorded, replays after end
// - Single realtime: trigger aborts and restarts segment
// - Segment single: each trigger plays next segment
// - Arb gate high: sequence plays while gate high
// - Baseband: three styles, three sources
module ptc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_trig,
  input wire logic key_trig,
  input wire logic bus_trig,
  input wire logic int_trig,
  input wire logic bb_enable,
  input wire ptc_pkg::ptc_bb_style_e bb_style,
  input wire logic bb_gate_low,
  input wire ptc_pkg::ptc_trig_cfg_s bb_cfg,
  input wire logic [ptc_pkg::PTC_LEN_W-1:0] bb_len,
  input wire logic arb_enable,
  input wire ptc_pkg::ptc_arb_style_e arb_style,
  input wire ptc_pkg::ptc_trig_cfg_s arb_cfg,
  input wire logic [ptc_pkg::PTC_SEG_W-1:0] arb_last_seg,
  input wire logic seg_we,
  input wire logic [ptc_pkg::PTC_SEG_W-1:0] seg_waddr,
  input wire logic [ptc_pkg::PTC_LEN_W-1:0] seg_wdata,
  output ptc_pkg::ptc_play_s bb_play,
  output ptc_pkg::ptc_play_s arb_play,
  output logic arb_pending
);
  // Synchroniser and edge detector on the external pin
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_trig;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  wire ext_rise = ext_s2_q & ~ext_s3_q;
  wire ext_fall = ~ext_s2_q & ext_s3_q;

  // Gate styles override source to external; baseband gate also overrides polarity to the gate level
  wire bb_gate = (bb_style == ptc_pkg::PTC_BB_GATE);
  wire arb_gate = (arb_style == ptc_pkg::PTC_ARB_GATE);
  wire bb_neg = bb_gate ? bb_gate_low : bb_cfg.pol_neg;
  wire bb_src_ext = bb_gate | (bb_cfg.src == ptc_pkg::PTC_SRC_EXT);
  wire arb_src_ext = arb_gate | (arb_cfg.src == ptc_pkg::PTC_SRC_EXT);
  wire bb_ext_edge = bb_neg ? ext_fall : ext_rise;
  wire arb_ext_edge = arb_cfg.pol_neg ? ext_fall : ext_rise;
  // Gate level; baseband active sense chosen by gate level setting, arb gate always active high
  wire bb_gate_on = ext_s2_q ^ bb_gate_low;
  wire arb_gate_on = ext_s2_q;

  // External trigger delay: one counter per engine, a new edge re-arms it
  logic [ptc_pkg::PTC_DLY_W-1:0] bb_dly_q, arb_dly_q;
  logic bb_dly_run_q, arb_dly_run_q;
  wire bb_dly_done = bb_dly_run_q & (bb_dly_q == ptc_pkg::PTC_DLY_ZERO);
  wire arb_dly_done = arb_dly_run_q & (arb_dly_q == ptc_pkg::PTC_DLY_ZERO);
  wire bb_use_dly = bb_cfg.dly_en & (bb_cfg.dly != ptc_pkg::PTC_DLY_ZERO);
  wire arb_use_dly = arb_cfg.dly_en & (arb_cfg.dly != ptc_pkg::PTC_DLY_ZERO);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bb_dly_q <= ptc_pkg::PTC_DLY_ZERO;
      bb_dly_run_q <= 1'b0;
    end else if (bb_ext_edge & bb_use_dly) begin
      bb_dly_q <= bb_cfg.dly - ptc_pkg::PTC_DLY_W'(1);
      bb_dly_run_q <= 1'b1;
    end else if (bb_dly_done) begin
      bb_dly_run_q <= 1'b0;
    end else if (bb_dly_run_q) begin
      bb_dly_q <= bb_dly_q - ptc_pkg::PTC_DLY_W'(1);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arb_dly_q <= ptc_pkg::PTC_DLY_ZERO;
      arb_dly_run_q <= 1'b0;
    end else if (arb_ext_edge & arb_use_dly) begin
      arb_dly_q <= arb_cfg.dly - ptc_pkg::PTC_DLY_W'(1);
      arb_dly_run_q <= 1'b1;
    end else if (arb_dly_done) begin
      arb_dly_run_q <= 1'b0;
    end else if (arb_dly_run_q) begin
      arb_dly_q <= arb_dly_q - ptc_pkg::PTC_DLY_W'(1);
    end
  end
  wire bb_ext_trig = bb_use_dly ? bb_dly_done : bb_ext_edge;
  wire arb_ext_trig = arb_use_dly ? arb_dly_done : arb_ext_edge;

  // Trigger source selection; baseband has no internal source
  wire bb_trig = bb_src_ext ? bb_ext_trig :
                 (bb_cfg.src == ptc_pkg::PTC_SRC_KEY) ? key_trig :
                 (bb_cfg.src == ptc_pkg::PTC_SRC_BUS) ? bus_trig : 1'b0;
  wire arb_trig = arb_src_ext ? arb_ext_trig :
                  (arb_cfg.src == ptc_pkg::PTC_SRC_KEY) ? key_trig :
                  (arb_cfg.src == ptc_pkg::PTC_SRC_BUS) ? bus_trig : int_trig;

  // Baseband playback: counter of samples left in the frame
  logic [ptc_pkg::PTC_LEN_W-1:0] bb_left_q;
  logic bb_run_q, bb_start_q;
  wire bb_last = bb_run_q & (bb_left_q == ptc_pkg::PTC_LEN_ONE);
  wire bb_cont = (bb_style == ptc_pkg::PTC_BB_CONT);
  wire bb_go = bb_enable & (bb_cont ? ~bb_run_q : (~bb_gate & bb_trig & ~bb_run_q));
  wire bb_gated_run = bb_enable & bb_gate & bb_gate_on;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bb_left_q <= ptc_pkg::PTC_LEN_ONE;
      bb_run_q <= 1'b0;
      bb_start_q <= 1'b0;
    end else begin
      bb_start_q <= bb_go;
      if (!bb_enable || (bb_gate && !bb_gate_on)) begin
        bb_run_q <= 1'b0;
      end else if (bb_go || (bb_gated_run && (!bb_run_q || bb_last))) begin
        bb_left_q <= bb_len;
        bb_run_q <= 1'b1;
      end else if (bb_last) begin
        bb_run_q <= 1'b0;
      end else if (bb_run_q) begin
        bb_left_q <= bb_left_q - ptc_pkg::PTC_LEN_W'(1);
      end
    end
  end

  // Arbitrary sequencer
  typedef enum logic [1:0] {ARB_IDLE, ARB_LOAD, ARB_PLAY} ptc_arb_st_e;
  ptc_arb_st_e arb_st_q, arb_st_d;
  logic [ptc_pkg::PTC_SEG_W-1:0] seg_q, seg_d;
  logic [ptc_pkg::PTC_LEN_W-1:0] arb_left_q, seg_len;
  logic pend_q;
  ptc_seg_mem u_mem (
    .clk(clk),
    .we(seg_we),
    .waddr(seg_waddr),
    .wdata(seg_wdata),
    .raddr(seg_d),
    .rdata(seg_len)
  );
  wire arb_busy = (arb_st_q != ARB_IDLE);
  wire arb_end = (arb_st_q == ARB_PLAY) & (arb_left_q == ptc_pkg::PTC_LEN_ONE);
  wire seg_at_last = (seg_q == arb_last_seg);
  wire [ptc_pkg::PTC_SEG_W-1:0] seg_next = seg_at_last ? ptc_pkg::PTC_SEG_FIRST :
                                          seg_q + ptc_pkg::PTC_SEG_W'(1);
  wire restart_style = (arb_style == ptc_pkg::PTC_ARB_CONT) |
                       (arb_style == ptc_pkg::PTC_ARB_RESTART);
  // Start/restart decisions per style
  wire arb_restart = arb_trig & arb_busy & restart_style;
  wire arb_idle_trig = arb_trig & ~arb_busy & ~arb_gate;
  wire arb_buf_go = arb_end & (pend_q | (arb_trig & (arb_style == ptc_pkg::PTC_ARB_BUFFER)));
  wire gate_go = arb_gate & arb_gate_on & (~arb_busy | arb_end);
  wire arb_go = arb_enable & (arb_idle_trig | arb_restart | arb_buf_go | gate_go);
  wire adv = (arb_style == ptc_pkg::PTC_ARB_SEGSINGLE) & arb_end;
  wire gate_adv = arb_gate & arb_end;

  // Next segment index feeds the memory read address
  always_comb begin
    seg_d = seg_q;
    if (!arb_enable) begin
      seg_d = ptc_pkg::PTC_SEG_FIRST;
    end else if (adv || gate_adv) begin
      seg_d = seg_next;
    end
  end
  always_comb begin
    arb_st_d = arb_st_q;
    case (arb_st_q)
      ARB_IDLE: if (arb_go) arb_st_d = ARB_LOAD;
      ARB_LOAD: begin
        if (arb_go) begin
          arb_st_d = ARB_LOAD;
        end else begin
          arb_st_d = ARB_PLAY;
        end
      end
      ARB_PLAY: begin
        if (arb_go) begin
          arb_st_d = ARB_LOAD;
        end else if (arb_end || (arb_gate && !arb_gate_on)) begin
          arb_st_d = ARB_IDLE;
        end
      end
      default: arb_st_d = ARB_IDLE;
    endcase
    if (!arb_enable) begin
      arb_st_d = ARB_IDLE;
    end
  end
  // Pending flag: never set in the end cycle, where a buffer-style trigger starts playback directly
  wire pend_set = arb_trig & arb_busy & ~arb_end & (arb_style == ptc_pkg::PTC_ARB_BUFFER);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arb_st_q <= ARB_IDLE;
      seg_q <= ptc_pkg::PTC_SEG_FIRST;
      pend_q <= 1'b0;
      arb_left_q <= ptc_pkg::PTC_LEN_ONE;
    end else begin
      arb_st_q <= arb_st_d;
      seg_q <= seg_d;
      pend_q <= arb_enable & (pend_set | (pend_q & ~arb_end));
      if (arb_st_q == ARB_LOAD) begin
        arb_left_q <= seg_len;
      end else if (arb_st_q == ARB_PLAY) begin
        arb_left_q <= arb_left_q - ptc_pkg::PTC_LEN_W'(1);
      end
    end
  end
  // Registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bb_play <= '0;
      arb_play <= '0;
      arb_pending <= 1'b0;
    end else begin
      bb_play.play <= bb_run_q;
      bb_play.start <= bb_start_q;
      bb_play.seg <= ptc_pkg::PTC_SEG_FIRST;
      arb_play.play <= (arb_st_q == ARB_PLAY);
      arb_play.start <= (arb_st_q == ARB_LOAD);
      arb_play.seg <= seg_q;
      arb_pending <= pend_q;
    end
  end

  a_ext_once: assert property (@(posedge clk) disable iff (!rstn)
    ext_rise |=> !ext_rise) else $error("edge counted twice");
  a_bb_gate_stop: assert property (@(posedge clk) disable iff (!rstn)
    (bb_gate && !bb_gate_on) |=> !bb_run_q) else $error("gate closed yet playing");
  a_bb_gate_low: assert property (@(posedge clk) disable iff (!rstn)
    (bb_gate && bb_gate_low && ext_s2_q) |=> !bb_run_q) else $error("gate low sense");
  a_bb_gate_run: assert property (@(posedge clk) disable iff (!rstn)
    (bb_enable && bb_gate && bb_gate_on && !bb_run_q) |=> bb_run_q)
    else $error("gate open yet idle");
  a_bb_single: assert property (@(posedge clk) disable iff (!rstn)
    (bb_enable && bb_style == ptc_pkg::PTC_BB_SINGLE && bb_trig && !bb_run_q) |=> bb_run_q)
    else $error("single trigger lost");
  a_gate_src: assert property (@(posedge clk) disable iff (!rstn)
    bb_gate |-> bb_src_ext) else $error("gate source not external");
  a_arb_ignore: assert property (@(posedge clk) disable iff (!rstn)
    (arb_style == ptc_pkg::PTC_ARB_IGNORE && arb_st_q == ARB_PLAY && !arb_end && arb_enable)
    |=> arb_st_q != ARB_LOAD) else $error("ignored trigger restarted");
  a_arb_restart: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && arb_trig && arb_busy && restart_style) |=> arb_st_q == ARB_LOAD)
    else $error("restart missed");
  a_arb_buffer: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && pend_q && arb_end) |=> arb_st_q == ARB_LOAD)
    else $error("buffered trigger lost");

  // Further guards on counters and sequencing
  // Delay counter steps down by one while armed
  a_bb_delay: assert property (@(posedge clk) disable iff (!rstn)
    (bb_dly_run_q && !bb_dly_done && !(bb_ext_edge && bb_use_dly))
    |=> bb_dly_q == $past(bb_dly_q) - ptc_pkg::PTC_DLY_W'(1)) else $error("delay count");
  // Running frame never reissues a start
  a_bb_no_retrig: assert property (@(posedge clk) disable iff (!rstn)
    (bb_run_q && !bb_last && bb_style == ptc_pkg::PTC_BB_SINGLE) |=> !bb_start_q)
    else $error("frame restarted");
  // Gate high opens a frame
  a_bb_gate_high: assert property (@(posedge clk) disable iff (!rstn)
    (bb_enable && bb_gate && !bb_gate_low && ext_s2_q && !bb_run_q) |=> bb_run_q)
    else $error("gate high idle");
  // Continuous style restarts on every trigger
  a_arb_cont: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && arb_style == ptc_pkg::PTC_ARB_CONT && arb_trig && arb_st_q == ARB_PLAY)
    |=> arb_st_q == ARB_LOAD) else $error("cont restart missed");
  // Internal source reaches the sequencer
  a_arb_src_int: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && arb_style == ptc_pkg::PTC_ARB_IGNORE && !arb_busy &&
     arb_cfg.src == ptc_pkg::PTC_SRC_INT && int_trig) |=> arb_st_q == ARB_LOAD)
    else $error("internal trigger lost");
  // Segment-single steps to the next segment
  a_seg_adv: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && arb_style == ptc_pkg::PTC_ARB_SEGSINGLE && arb_end && !seg_at_last)
    |=> seg_q == $past(seg_q) + ptc_pkg::PTC_SEG_W'(1)) else $error("segment not advanced");
  // Wrap after the last segment
  a_seg_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && arb_style == ptc_pkg::PTC_ARB_SEGSINGLE && arb_end && seg_at_last)
    |=> seg_q == ptc_pkg::PTC_SEG_FIRST) else $error("segment not wrapped");
  // Closed gate halts the sequence
  a_arb_gate_halt: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && arb_gate && !arb_gate_on && !pend_q && arb_st_q == ARB_PLAY)
    |=> arb_st_q == ARB_IDLE) else $error("gate closed yet playing");
  // Buffered trigger is recorded
  a_pend_set: assert property (@(posedge clk) disable iff (!rstn)
    (arb_enable && pend_set) |=> pend_q) else $error("trigger not buffered");
  // Play output follows the sequencer state
  a_arb_play_out: assert property (@(posedge clk) disable iff (!rstn)
    arb_st_q == ARB_PLAY |=> arb_play.play) else $error("play output lost");
endmodule
`default_nettype wire

/* File: testbench/ptc_pulse_src.sv */
`default_nettype none
// Far-side pulse source that drives the trigger/gate pin
module ptc_pulse_src (
  input wire logic clk,
  input wire logic fire,
  input wire logic neg,
  input wire logic [7:0] width,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q = 8'h00;
  // Active span counter; idle level is the inactive polarity
  always_ff @(posedge clk) begin
    if (fire) begin
      left_q <= width;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  assign pin = (left_q != 8'h00) ^ neg;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, fire, neg, key_trig, bus_trig, int_trig, ext_trig;
  logic bb_enable, bb_gate_low, arb_enable, seg_we, arb_pending;
  logic [7:0] width;
  ptc_pkg::ptc_bb_style_e bb_style;
  ptc_pkg::ptc_arb_style_e arb_style;
  ptc_pkg::ptc_trig_cfg_s bb_cfg, arb_cfg;
  logic [15:0] bb_len, seg_wdata;
  logic [2:0] arb_last_seg, seg_waddr;
  ptc_pkg::ptc_play_s bb_play, arb_play;
  int num_errors, tests_run, seed, bp, bs, ap, ast, pend, lat, lt[2];
  int xs[4] = '{2, 1, 2, 2};
  logic [15:0] len[8];
  logic [2:0] segs[$];
  ptc_pulse_src src (.clk(clk), .fire(fire), .neg(neg), .width(width), .pin(ext_trig));
  ptc_top dut (.clk(clk), .rstn(rstn), .ext_trig(ext_trig), .key_trig(key_trig),
    .bus_trig(bus_trig), .int_trig(int_trig), .bb_enable(bb_enable), .bb_style(bb_style),
    .bb_gate_low(bb_gate_low), .bb_cfg(bb_cfg), .bb_len(bb_len), .arb_enable(arb_enable),
    .arb_style(arb_style), .arb_cfg(arb_cfg), .arb_last_seg(arb_last_seg), .seg_we(seg_we),
    .seg_waddr(seg_waddr), .seg_wdata(seg_wdata), .bb_play(bb_play), .arb_play(arb_play),
    .arb_pending(arb_pending));
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] inr(input int v, input int lo, input int hi);
    return 16'(v >= lo && v <= hi);
  endfunction
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Sampled on the falling edge, where registered outputs have settled
  task automatic measure(input int n);
    bp = 0; bs = 0; ap = 0; ast = 0; pend = 0; lat = -1;
    segs.delete();
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (bb_play.start === 1'b1 && lat < 0) lat = i;
      bp += (bb_play.play === 1'b1);
      bs += (bb_play.start === 1'b1);
      ap += (arb_play.play === 1'b1);
      pend += (arb_pending === 1'b1);
      if (arb_play.start === 1'b1) begin
        ast++;
        segs.push_back(arb_play.seg);
      end
    end
  endtask
  // One request from source s; external goes through the pulse source
  task automatic trig(input int s, input logic [7:0] w);
    @(posedge clk);
    key_trig <= (s == 0);
    fire <= (s == 1);
    width <= w;
    bus_trig <= (s == 2);
    int_trig <= (s == 3);
    @(posedge clk);
    {key_trig, fire, bus_trig, int_trig} <= 4'h0;
  endtask
  task automatic arb(input int st, input int s, input logic [2:0] last);
    @(posedge clk);
    arb_enable <= 1'b0;
    @(posedge clk);
    arb_style <= ptc_pkg::ptc_arb_style_e'(st);
    arb_cfg <= '{ptc_pkg::ptc_src_e'(s), 1'b0, 1'b0, 16'h0000};
    arb_last_seg <= last;
    arb_enable <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  // Hang guard, far beyond the expected run of about 1000 cycles
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    seed = 32'h6106;
    {rstn, fire, neg, key_trig, bus_trig, int_trig, bb_enable, bb_gate_low} = 8'h00;
    {arb_enable, seg_we, width, seg_waddr, arb_last_seg, seg_wdata} = 32'h0;
    bb_style = ptc_pkg::PTC_BB_SINGLE;
    arb_style = ptc_pkg::PTC_ARB_CONT;
    bb_cfg = '0;
    arb_cfg = '0;
    bb_len = 16'h0004;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(16'({bb_play, arb_play, arb_pending}), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      len[i] = 16'(6 + ($random(seed) & 7));
      @(posedge clk);
      {seg_we, seg_waddr, seg_wdata} <= {1'b1, 3'(i), len[i]};
    end
    @(posedge clk);
    seg_we <= 1'b0;
    // Baseband single, both polarities, delay off then 10 cycles
    bb_len <= 16'(3 + ($random(seed) & 7));
    bb_enable <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      bb_cfg <= '{ptc_pkg::PTC_SRC_EXT, 1'(p), 1'(p), 16'h000a};
      neg <= 1'(p);
      repeat (10) @(posedge clk);
      fork measure(60); trig(1, 8'h02); join
      chk(16'(bp), bb_len);
      chk(16'(bs), 16'h0001);
      lt[p] = lat;
    end
    chk(inr(lt[1] - lt[0], 9, 11), 16'h0001);
    $display("test baseband single done");
    // Gate with a key source configured, which the gate style overrides
    bb_style <= ptc_pkg::PTC_BB_GATE;
    bb_cfg <= '{ptc_pkg::PTC_SRC_KEY, 1'b0, 1'b0, 16'h0000};
    neg <= 1'b0;
    for (int g = 0; g < 2; g++) begin
      bb_gate_low <= 1'(g);
      repeat (10) @(posedge clk);
      fork measure(60); trig(1, 8'd40); join
      if (g == 0) chk(inr(bp, 34, 46), 16'h0001);
      else chk(inr(bp, 14, 26), 16'h0001);
    end
    bb_style <= ptc_pkg::PTC_BB_CONT;
    repeat (5) @(posedge clk);
    measure(30);
    chk(inr(bp + bs, 29, 31), 16'h0001);
    bb_enable <= 1'b0;
    $display("test baseband gate done");
    // Two close triggers per repeat style, a different source each time
    for (int m = 0; m < 4; m++) begin
      arb(m, m, 3'h0);
      fork
        measure(80);
        begin
          trig(m, 8'h02);
          repeat (3 + ($random(seed) & 1)) @(posedge clk);
          trig(m, 8'h02);
        end
      join
      chk(16'(m == 0 ? ast >= 2 : ast == xs[m]), 16'h0001);
      if (m == 1) chk(16'(ap), len[0]);
      if (m == 2) chk(16'(pend > 0), 16'h0001);
    end
    $display("test arb repeat styles done");
    arb(4, 2, 3'h2);
    for (int k = 0; k < 4; k++) begin
      fork measure(40); trig(2, 8'h00); join
      chk(16'(segs[0]), 16'(k % 3));
      chk(16'(ap), len[k % 3]);
    end
    $display("test segment single done");
    arb(5, 1, 3'h1);
    fork measure(100); trig(1, 8'd80); join
    chk(inr(ap + ast, 76, 84), 16'h0001);
    chk(16'(segs[1]), 16'h0001);
    measure(20);
    chk(16'(ap), 16'h0000);
    $display("test arb gate done");
    give_verdict();
  end
endmodule
`default_nettype wire
